// [hw/access_fault_frame_pkg.sv]
// shared constants and types for the access fault frame builder
package access_fault_frame_pkg;

  // frame geometry
  localparam int FRAME_WORDS = 30;
  localparam logic [31:0] FRAME_BYTES = 32'h0000_003C;
  localparam int TRACE_COPY_WORDS = 6;
  localparam logic [31:0] TRACE_COPY_OFS = 32'h0000_0030;
  localparam logic [3:0] FMT_ACCESS = 4'h7;
  localparam logic [3:0] FMT_SIX = 4'h2;

  // frame word indices (byte offset / 2)
  localparam int W_SR = 0;
  localparam int W_PC = 1;
  localparam int W_FMT = 3;
  localparam int W_EA = 4;
  localparam int W_SSW = 6;
  localparam int W_WB3S = 7;
  localparam int W_WB2S = 8;
  localparam int W_FIRST_WRITEBACK_STATUS = 9;
  localparam int W_FA = 10;
  localparam int W_WB3A = 12;
  localparam int W_WB3D = 14;
  localparam int W_WB2A = 16;
  localparam int W_WB2D = 18;
  localparam int W_WB1A = 20;
  localparam int W_WB1D = 22;
  localparam int W_PD1 = 24;
  localparam int W_PD2 = 26;
  localparam int W_PD3 = 28;

  // fault status word bit positions
  localparam int SSW_FPPOST = 15;
  localparam int SSW_FPUNIMPL = 14;
  localparam int SSW_TRACE = 13;
  localparam int SSW_MOVE = 12;
  localparam int SSW_SPAN = 11;
  localparam int SSW_XLAT = 10;
  localparam int SSW_LOCK = 9;
  localparam int SSW_READ = 8;
  localparam int SSW_UNDEF = 7;
  localparam int SSW_SIZE_LO = 5;
  localparam int SSW_TYPE_LO = 3;
  localparam int SSW_MOD_LO = 0;

  // addressing mode codes for move restart
  localparam logic [2:0] MODE_INDEXED = 3'h6;
  localparam logic [2:0] MODE_SPECIAL = 3'h7;
  localparam logic [2:0] REG_PCREL_DISP = 3'h2;
  localparam logic [2:0] REG_PCREL_INDEX = 3'h3;

  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAST_SSW = 8'h08;
  localparam logic [7:0] REG_LAST_EA = 8'h0C;
  localparam int CTRL_FAULT_VEC_LO = 0;
  localparam int CTRL_TRACE_VEC_LO = 16;
  localparam logic [11:0] FAULT_VEC_RESET = 12'h008;
  localparam logic [11:0] TRACE_VEC_RESET = 12'h024;
  localparam int STAT_STATE_LO = 0;
  localparam int STAT_KIND_LO = 2;
  localparam int STAT_COUNT_LO = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_DONE = 2'b10
  } state_t;

  // what the exception return does next
  typedef enum logic [2:0] {
    RK_RESUME = 3'b000,
    RK_MOVE_STACKED_EA = 3'b001,
    RK_MOVE_RECALC_EA = 3'b010,
    RK_TRACE = 3'b011,
    RK_FP_POST = 3'b100,
    RK_FLINE = 3'b101
  } ret_kind_t;

endpackage : access_fault_frame_pkg

// [hw/access_fault_frame_builder.sv]
// access fault frame builder: frame push, exception return decode, axi4-lite registers
//
// Notes on behaviour
// - any access fault except an instruction address error pushes a 30-word frame.
// - frame holds status, faulted access details and all pending write-backs.
// - effective address field is filled whenever any continuation flag is set.
// - status word layout: 15 fp-post .. 12 move, 11..8 flags, size, type, modifier.
// - fault with fp post exception pending sets fp-post flag; return takes that vector.
// - fault after trace recognised sets trace flag, traced instruction address as ea.
// - fp post during trace wins: fp-post set, trace clear, calculated ea stored.
// - fault with unimplemented fp pending sets its flag, stores ea, return takes f-line.
// - traced unimplemented fp instruction: unimplemented flag set, trace flag clear.
// - fault with trace pending sets the trace flag.
// - return with trace: copy 12 bytes up by 30h, sp plus 30h, format 2, trace.
// - bus error in multi-register move sets move flag, saves calculated ea.
// - move restart uses stacked ea for pc-relative or indexed indirect modes.
// - translation fault on second page of a page-crossing access sets span flag.
// - translation flag for nonresident or privilege fault, clear for plain bus error.
// - locked flag set only for locked read-modify-write transfers.
// - read flag set for reads, clear for writes.
// - size is original access size; line fill from read miss reports the read size.
// - type and modifier fields copy the faulted transfer's bus attribute codes.
// - three write-back status words; line push or line move fault zeroes the first.
// - return with no flag set restores status and pc, sp plus 30 words, resumes.
// - at most one continuation flag is ever set; several make return undefined.
`timescale 1ns/10ps
module access_fault_frame_builder
  import access_fault_frame_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  // fault report from the core
  input wire logic faultValid,
  output logic faultReady,
  input wire logic faultInstrAddrErr,
  input wire logic [15:0] curSr,
  input wire logic [31:0] curPc,
  input wire logic [31:0] curSp,
  input wire logic [31:0] faultAddr,
  input wire logic [31:0] calcEa,
  input wire logic [31:0] traceAddr,
  input wire logic fpPostPending,
  input wire logic fpUnimplPending,
  input wire logic tracePending,
  input wire logic multiMoveFault,
  input wire logic secondPageAccess,
  input wire logic xlatNonresident,
  input wire logic xlatPrivilege,
  input wire logic lockedXfer,
  input wire logic readXfer,
  input wire logic [1:0] xferSize,
  input wire logic [1:0] origReadSize,
  input wire logic lineFillFromRead,
  input wire logic [1:0] xferType,
  input wire logic [2:0] xferModifier,
  input wire logic linePushFault,
  input wire logic lineMoveWriteFault,
  input wire logic [23:0] wbStatusAll,
  input wire logic [95:0] wbAddrAll,
  input wire logic [95:0] wbDataAll,
  input wire logic [95:0] pushDataAll,
  // exception return request for an access error frame
  input wire logic retValid,
  output logic retReady,
  input wire logic [15:0] retSr,
  input wire logic [31:0] retPc,
  input wire logic [31:0] retEa,
  input wire logic [15:0] retSsw,
  input wire logic [31:0] retSp,
  input wire logic [2:0] retEaMode,
  input wire logic [2:0] retEaReg,
  // result of the exception return
  output logic retDone,
  output logic [2:0] retKind,
  output logic [31:0] retEaOut,
  // stack write port
  output logic stkWrValid,
  input wire logic stkWrReady,
  output logic [31:0] stkWrAddr,
  output logic [15:0] stkWrData,
  // stack pointer update
  output logic spLoad,
  output logic [31:0] spNew,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // split a long word into one 16-bit half
  function automatic logic [15:0] half(input logic [31:0] v, input logic hi);
    half = hi ? v[31:16] : v[15:0];
  endfunction : half

  // pick one 32-bit lane of a packed triple (lane 0 is write-back 1)
  function automatic logic [31:0] lane(input logic [95:0] v, input int idx);
    lane = v[32*idx +: 32];
  endfunction : lane

  state_t state_q, state_d;
  logic [15:0] frame_q [FRAME_WORDS];
  logic [4:0] pushIdx_q;
  logic [4:0] pushLast_q;
  logic [31:0] pushBase_q;
  logic [31:0] spFinal_q;
  logic retMode_q;
  logic [2:0] kind_q;
  logic [31:0] kindEa_q;
  logic [15:0] lastSsw_q;
  logic [31:0] lastEa_q;
  logic [COUNT_W-1:0] faultCount_q;
  logic [11:0] faultVec_q;
  logic [11:0] traceVec_q;

  // continuation flags in priority order so only one is ever set
  wire flagFpPost = fpPostPending;
  wire flagFpUnimpl = fpUnimplPending && !fpPostPending;
  wire flagTrace = tracePending && !fpPostPending && !fpUnimplPending;
  wire flagMove = multiMoveFault && !fpPostPending && !fpUnimplPending && !tracePending;
  wire anyFlag = flagFpPost || flagFpUnimpl || flagTrace || flagMove;
  wire xlatFault = xlatNonresident || xlatPrivilege;

  // ea field: traced instruction for trace, calculated ea otherwise, zero when unused
  wire [31:0] eaField = !anyFlag ? 32'h0000_0000 :
                        flagTrace ? traceAddr : calcEa;

  wire [1:0] sizeField = lineFillFromRead ? origReadSize : xferSize;

  // fault status word assembly; undefined bit driven to zero
  wire [15:0] fault_status_word = {flagFpPost, flagFpUnimpl, flagTrace, flagMove,
                     xlatFault && secondPageAccess,
                     xlatFault,
                     lockedXfer,
                     readXfer,
                     1'b0,
                     sizeField, xferType, xferModifier};

  // first write-back status forced invalid for line push and line move faults
  wire [7:0] wb1Status = (linePushFault || lineMoveWriteFault) ? 8'h00 : wbStatusAll[7:0];

  // full frame image for a fault push
  logic [15:0] faultFrame [FRAME_WORDS];
  always_comb begin
    for (int i = 0; i < FRAME_WORDS; i++) begin
      faultFrame[i] = 16'h0000;
    end
    faultFrame[W_SR] = curSr;
    faultFrame[W_PC] = half(curPc, 1'b1);
    faultFrame[W_PC + 1] = half(curPc, 1'b0);
    faultFrame[W_FMT] = {FMT_ACCESS, faultVec_q};
    faultFrame[W_EA] = half(eaField, 1'b1);
    faultFrame[W_EA + 1] = half(eaField, 1'b0);
    faultFrame[W_SSW] = fault_status_word;
    faultFrame[W_WB3S] = {8'h00, wbStatusAll[23:16]};
    faultFrame[W_WB2S] = {8'h00, wbStatusAll[15:8]};
    faultFrame[W_FIRST_WRITEBACK_STATUS] = {8'h00, wb1Status};
    faultFrame[W_FA] = half(faultAddr, 1'b1);
    faultFrame[W_FA + 1] = half(faultAddr, 1'b0);
    for (int k = 0; k < 3; k++) begin
      // write-back k+1 sits at decreasing frame offsets: wb3 first
      faultFrame[W_WB1A - 4*k] = half(lane(wbAddrAll, k), 1'b1);
      faultFrame[W_WB1A - 4*k + 1] = half(lane(wbAddrAll, k), 1'b0);
      faultFrame[W_WB1D - 4*k] = half(lane(wbDataAll, k), 1'b1);
      faultFrame[W_WB1D - 4*k + 1] = half(lane(wbDataAll, k), 1'b0);
      faultFrame[W_PD1 + 2*k] = half(lane(pushDataAll, k), 1'b1);
      faultFrame[W_PD1 + 2*k + 1] = half(lane(pushDataAll, k), 1'b0);
    end
  end

  // trace return: first six words rebuilt as a six-word frame
  logic [15:0] traceFrame [TRACE_COPY_WORDS];
  always_comb begin
    traceFrame[W_SR] = retSr;
    traceFrame[W_PC] = half(retPc, 1'b1);
    traceFrame[W_PC + 1] = half(retPc, 1'b0);
    traceFrame[W_FMT] = {FMT_SIX, traceVec_q};
    traceFrame[W_EA] = half(retEa, 1'b1);
    traceFrame[W_EA + 1] = half(retEa, 1'b0);
  end

  // return decode; bit 7 is never looked at, priority resolves illegal multi-flag frames
  wire stackedEaMode = (retEaMode == MODE_INDEXED) ||
                       (retEaMode == MODE_SPECIAL &&
                        (retEaReg == REG_PCREL_DISP || retEaReg == REG_PCREL_INDEX));
  wire [2:0] retKindD = retSsw[SSW_FPPOST] ? RK_FP_POST :
                        retSsw[SSW_FPUNIMPL] ? RK_FLINE :
                        retSsw[SSW_TRACE] ? RK_TRACE :
                        retSsw[SSW_MOVE] ? (stackedEaMode ? RK_MOVE_STACKED_EA : RK_MOVE_RECALC_EA) :
                        RK_RESUME;
  wire retIsTrace = (retKindD == RK_TRACE);
  wire [31:0] retSpFinal = retIsTrace ? retSp + TRACE_COPY_OFS : retSp + FRAME_BYTES;

  // handshakes
  wire faultTake = faultValid && faultReady && !faultInstrAddrErr;
  wire faultDrop = faultValid && faultReady && faultInstrAddrErr;
  wire retTake = retValid && retReady && !faultValid;
  wire pushStep = stkWrValid && stkWrReady;
  wire pushEnd = pushStep && (pushIdx_q == pushLast_q);
  wire [4:0] nextIdx = pushStep ? pushIdx_q + 5'h01 : pushIdx_q; // current word until it is taken

  // state sequencing: idle, push frame words, finish
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (faultTake) begin
          state_d = ST_PUSH;
        end else if (retTake) begin
          state_d = retIsTrace ? ST_PUSH : ST_DONE;
        end
      end
      ST_PUSH: begin
        if (pushEnd) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // frame storage: whole frame on a fault, first six words on a trace return
  always_ff @(posedge mclk) begin
    if (state_q == ST_IDLE && faultTake) begin
      frame_q <= faultFrame;
    end else if (state_q == ST_IDLE && retTake && retIsTrace) begin
      for (int i = 0; i < TRACE_COPY_WORDS; i++) begin
        frame_q[i] <= traceFrame[i];
      end
    end
  end

  // push bookkeeping: base address, count and final stack pointer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pushIdx_q <= 5'h00;
      pushLast_q <= 5'h00;
      pushBase_q <= 32'h0000_0000;
      spFinal_q <= 32'h0000_0000;
      retMode_q <= 1'b0;
    end else if (state_q == ST_IDLE && faultTake) begin
      pushIdx_q <= 5'h00;
      pushLast_q <= 5'(FRAME_WORDS - 1);
      pushBase_q <= curSp - FRAME_BYTES;
      spFinal_q <= curSp - FRAME_BYTES;
      retMode_q <= 1'b0;
    end else if (state_q == ST_IDLE && retTake) begin
      pushIdx_q <= 5'h00;
      pushLast_q <= 5'(TRACE_COPY_WORDS - 1);
      pushBase_q <= retSp + TRACE_COPY_OFS;
      spFinal_q <= retSpFinal;
      retMode_q <= 1'b1;
    end else if (pushStep) begin
      pushIdx_q <= pushIdx_q + 5'h01;
    end
  end

  // stack write port; payload held steady until the core accepts it
  // issuing waits for the push state so word 0 reads the freshly stored frame, not a stale one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stkWrValid <= 1'b0;
      stkWrAddr <= 32'h0000_0000;
      stkWrData <= 16'h0000;
    end else if (state_q == ST_PUSH && (!stkWrValid || stkWrReady) && !pushEnd) begin
      stkWrValid <= 1'b1;
      stkWrAddr <= pushBase_q + {26'h000_0000, nextIdx, 1'b0};
      stkWrData <= frame_q[nextIdx];
    end else if (pushStep) begin
      stkWrValid <= 1'b0;
    end
  end

  // finish pulses: stack pointer load and return outcome
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spLoad <= 1'b0;
      spNew <= 32'h0000_0000;
      retDone <= 1'b0;
      retKind <= RK_RESUME;
      retEaOut <= 32'h0000_0000;
    end else begin
      spLoad <= (state_q == ST_DONE);
      retDone <= (state_q == ST_DONE) && retMode_q;
      if (state_q == ST_DONE) begin
        spNew <= spFinal_q;
        retKind <= kind_q;
        retEaOut <= kindEa_q;
      end
    end
  end

  // return outcome capture and status history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      kind_q <= RK_RESUME;
      kindEa_q <= 32'h0000_0000;
      lastSsw_q <= 16'h0000;
      lastEa_q <= 32'h0000_0000;
      faultCount_q <= '0;
    end else if (state_q == ST_IDLE && faultTake) begin
      lastSsw_q <= fault_status_word;
      lastEa_q <= eaField;
      faultCount_q <= faultCount_q + 1'b1;
    end else if (state_q == ST_IDLE && retTake) begin
      kind_q <= retKindD;
      kindEa_q <= retEa;
    end
  end

  // ready only while idle; a fault beats a return in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      faultReady <= 1'b0;
      retReady <= 1'b0;
    end else begin
      faultReady <= (state_d == ST_IDLE) && !faultTake && !faultDrop;
      retReady <= (state_d == ST_IDLE) && !faultTake && !faultDrop && !retTake;
    end
  end

  // axi4-lite write side: address and data latched in either order
  logic awFull_q;
  logic wFull_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  wire awHs = s_axi_awvalid && s_axi_awready;
  wire wHs = s_axi_wvalid && s_axi_wready;
  wire wrCommit = awFull_q && wFull_q && !s_axi_bvalid;
  wire wrCtrl = wrCommit && (awAddr_q == REG_CTRL);
  wire wrKnown = (awAddr_q == REG_CTRL) || (awAddr_q == REG_STATUS) ||
                 (awAddr_q == REG_LAST_SSW) || (awAddr_q == REG_LAST_EA);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awFull_q <= 1'b0;
      wFull_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (awHs) begin
        awFull_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrCommit) begin
        awFull_q <= 1'b0;
      end
      if (wHs) begin
        wFull_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrCommit) begin
        wFull_q <= 1'b0;
      end
      s_axi_awready <= !awFull_q && !awHs && !s_axi_bvalid && !s_axi_awready;
      s_axi_wready <= !wFull_q && !wHs && !s_axi_bvalid && !s_axi_wready;
      if (wrCommit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register: vector offsets placed in the frame format words
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      faultVec_q <= FAULT_VEC_RESET;
      traceVec_q <= TRACE_VEC_RESET;
    end else if (wrCtrl) begin
      if (wStrb_q[0]) faultVec_q[7:0] <= wData_q[CTRL_FAULT_VEC_LO +: 8];
      if (wStrb_q[1]) faultVec_q[11:8] <= wData_q[CTRL_FAULT_VEC_LO + 8 +: 4];
      if (wStrb_q[2]) traceVec_q[7:0] <= wData_q[CTRL_TRACE_VEC_LO +: 8];
      if (wStrb_q[3]) traceVec_q[11:8] <= wData_q[CTRL_TRACE_VEC_LO + 8 +: 4];
    end
  end

  // axi4-lite read side: one read at a time, answer registered
  wire [31:0] statusWord = (32'(faultCount_q) << STAT_COUNT_LO) |
                           (32'(kind_q) << STAT_KIND_LO) | (32'(state_q) << STAT_STATE_LO);
  wire [31:0] ctrlWord = (32'(traceVec_q) << CTRL_TRACE_VEC_LO) | (32'(faultVec_q) << CTRL_FAULT_VEC_LO);
  wire rdKnown = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS) ||
                 (s_axi_araddr == REG_LAST_SSW) || (s_axi_araddr == REG_LAST_EA);
  wire [31:0] rdMux = (s_axi_araddr == REG_CTRL) ? ctrlWord :
                      (s_axi_araddr == REG_STATUS) ? statusWord :
                      (s_axi_araddr == REG_LAST_SSW) ? {16'h0000, lastSsw_q} :
                      (s_axi_araddr == REG_LAST_EA) ? lastEa_q : 32'h0000_0000;
  wire arHs = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !arHs && !s_axi_arready;
      if (arHs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdKnown ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : access_fault_frame_builder

// [dv/access_fault_frame_sva.sv]
// concurrent checks on the access fault frame builder ports
`timescale 1ns/10ps
module access_fault_frame_sva
  import access_fault_frame_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic mclk, rst_n, faultValid, faultReady, faultInstrAddrErr,
  input wire logic stkWrValid, stkWrReady, spLoad, retValid, retReady, retDone,
  input wire logic [2:0] retKind,
  input wire logic [15:0] retSsw, stkWrData,
  input wire logic [31:0] curSp, stkWrAddr, spNew, retSp
);
  logic [31:0] baseQ;
  logic [5:0] cntQ;
  wire fTake = faultValid && faultReady;
  wire rTake = retValid && retReady && !faultValid;
  // stack pointer at the last fault and words taken since the last request; reset per request so returns count too
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baseQ <= 32'h0;
      cntQ <= 6'h0;
    end else begin
      if (fTake) baseQ <= curSp;
      cntQ <= (fTake || rTake) ? 6'h0 : cntQ + {5'h0, stkWrValid && stkWrReady};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_PUSH_START: assert property (fTake && !faultInstrAddrErr |-> ##2 stkWrValid &&
    stkWrAddr == $past(curSp, 2) - FRAME_BYTES) else $error("frame push start wrong");
  AST_ADDR_ERR: assert property (fTake && faultInstrAddrErr |=> !stkWrValid [*4])
    else $error("address error pushed a frame");
  AST_FRAME_SP: assert property (spLoad && !retDone |-> spNew == baseQ - FRAME_BYTES && cntQ == 6'h1E)
    else $error("frame length or stack pointer wrong");
  AST_ADDR_STEP: assert property (stkWrValid && stkWrReady ##1 stkWrValid |->
    stkWrAddr == $past(stkWrAddr) + 32'h2) else $error("stack words not ascending");
  AST_HOLD: assert property (stkWrValid && !stkWrReady |=> stkWrValid && $stable(stkWrAddr) &&
    $stable(stkWrData)) else $error("stack write dropped while stalled");
  AST_RESUME: assert property (rTake && retSsw[15:12] == 4'h0 |-> ##2 retDone && spLoad &&
    retKind == RK_RESUME && spNew == $past(retSp, 2) + FRAME_BYTES) else $error("plain return wrong");
  AST_TRACE_RET: assert property (rTake && retSsw[15:12] == 4'h2 |-> ##[2:60] retDone &&
    retKind == RK_TRACE && cntQ == 6'h6) else $error("trace return wrong");
  AST_BUSY: assert property (fTake |=> !faultReady && !retReady)
    else $error("request taken while busy");
  cover property (fTake && !faultInstrAddrErr);
  cover property (retDone && retKind == RK_TRACE);
  cover property (rTake && retSsw[12]);
endmodule : access_fault_frame_sva
bind access_fault_frame_builder access_fault_frame_sva #(.COUNT_W(COUNT_W)) chk_u (.*);

// [dv/access_fault_frame_builder_test.sv]
// self-checking bench for the access fault frame builder
`timescale 1ns/10ps
module access_fault_frame_builder_test;
  import access_fault_frame_pkg::*;
  logic mclk = '0, rst_n = '0, faultValid = '0, faultInstrAddrErr = '0, retValid = '0, stkWrReady = '1;
  logic fpPostPending = '0, fpUnimplPending = '0, tracePending = '0, multiMoveFault = '0, secondPageAccess = '0;
  logic xlatNonresident = '0, xlatPrivilege = '0, lockedXfer = '0, readXfer = '0, lineFillFromRead = '0;
  logic linePushFault = '0, lineMoveWriteFault = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [1:0] xferSize = 2'h2, origReadSize = 2'h1, xferType = 2'h1;
  logic [2:0] xferModifier = 3'h5, retEaMode = '0, retEaReg = '0;
  logic [15:0] curSr = 16'h2700, retSr = 16'h2000, retSsw = '0;
  logic [31:0] curPc = 32'h400, curSp = 32'h2000, faultAddr = 32'h9ABC, calcEa = 32'h1234, traceAddr = 32'h5678;
  logic [31:0] retPc = 32'h800, retEa = 32'h7770, retSp = 32'h3000, s_axi_wdata = '0;
  logic [23:0] wbStatusAll = 24'h332211;
  logic [95:0] wbAddrAll = '1, wbDataAll = '0, pushDataAll = '1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic faultReady, retReady, retDone, stkWrValid, spLoad, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [2:0] retKind;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] stkWrData;
  logic [31:0] retEaOut, stkWrAddr, spNew, s_axi_rdata;
  int n_mismatch = 0, checks = 0;

  access_fault_frame_builder #(.COUNT_W(16)) dut_u (.*);

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // bounded wait ran out: count it and stop
  task tmo;
    n_mismatch++;
    complete_run;
  endtask : tmo

  // raise one fault, stall the stack port now and then, judge the pushed frame
  task automatic flt(input logic [12:0] f, input logic [15:0] fault_status_word, input logic [31:0] ea);
    logic [15:0] w [30];
    int k;
    @(posedge mclk);
    {faultInstrAddrErr, lineMoveWriteFault, linePushFault, lineFillFromRead, fpPostPending, fpUnimplPending,
      tracePending, multiMoveFault, secondPageAccess, xlatNonresident, xlatPrivilege, lockedXfer, readXfer} <= f;
    faultValid <= '1;
    curSp <= curSp + 32'h100;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (faultReady !== 1'b1 && k < 50);
    faultValid <= '0;
    if (k == 50) tmo;
    if (f[12]) begin
      repeat (6) @(posedge mclk);
      chk(stkWrValid, 0);
      return;
    end
    k = 0;
    for (int t = 0; t < 200 && k < 30; t++) begin
      @(posedge mclk);
      if (stkWrValid === 1'b1 && stkWrReady === 1'b1) begin
        w[k] = stkWrData;
        k++;
      end
      stkWrReady <= t[1:0] != 2'h0;
    end
    stkWrReady <= '1;
    for (int t = 0; t < 20 && spLoad !== 1'b1; t++) @(posedge mclk);
    chk(spLoad, 1);
    chk(spNew, curSp - FRAME_BYTES);
    chk(k, 30);
    chk(w[0], curSr);
    chk(w[3], {FMT_ACCESS, FAULT_VEC_RESET});
    chk(w[6] & 16'hFF7F, fault_status_word);
    chk({w[4], w[5]}, ea);
    chk(w[9], (f[11] || f[10]) ? 16'h0 : 16'h0011);
    chk(w[8], 16'h0022);
    chk(w[7], 16'h0033);
    chk({w[10], w[11]}, faultAddr);
  endtask : flt

  // one exception return and the action it picks
  task automatic ret(input logic [15:0] fault_status_word, input logic [2:0] md, input logic [2:0] rg, input logic [2:0] kind);
    int k;
    @(posedge mclk);
    retSsw <= fault_status_word;
    retEaMode <= md;
    retEaReg <= rg;
    retValid <= '1;
    retSp <= retSp + 32'h40;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (retReady !== 1'b1 && k < 50);
    retValid <= '0;
    if (k == 50) tmo;
    for (int t = 0; t < 60 && retDone !== 1'b1; t++) @(posedge mclk);
    chk(retDone, 1);
    chk(retKind, kind);
    chk(retEaOut, retEa);
    chk(spLoad, 1);
    chk(spNew, retSp + ((kind == RK_TRACE) ? TRACE_COPY_OFS : FRAME_BYTES));
  endtask : ret

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    bit done = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    for (t = 0; t < 50 && !done; t++) begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= '0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= '0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= '0;
        done = 1'b1;
        chk(s_axi_bresp, RESP_OKAY);
      end
    end
    if (!done) tmo;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    bit done = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    for (t = 0; t < 50 && !done; t++) begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= '0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= '0;
        done = 1'b1;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
      end
    end
    if (!done) tmo;
  endtask : rd

  // main sequence: faults of every flavour, every return action, then the registers
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= '1;
    repeat (2) @(posedge mclk);
    rd(REG_CTRL, {4'h0, TRACE_VEC_RESET, 4'h0, FAULT_VEC_RESET}, RESP_OKAY);
    flt(13'h0141, 16'h814D, calcEa);
    flt(13'h0041, 16'h214D, traceAddr);
    flt(13'h00C0, 16'h404D, calcEa);
    flt(13'h0022, 16'h124D, calcEa);
    flt(13'h0219, 16'h0D2D, 32'h0);
    flt(13'h0404, 16'h044D, 32'h0);
    flt(13'h0810, 16'h004D, 32'h0);
    flt(13'h1000, 16'h0, 32'h0);
    rd(REG_LAST_SSW, 32'h004D, RESP_OKAY);
    ret(16'h0000, 3'h0, 3'h0, RK_RESUME);
    ret(16'h0080, 3'h0, 3'h0, RK_RESUME);
    ret(16'h8000, 3'h0, 3'h0, RK_FP_POST);
    ret(16'h4000, 3'h0, 3'h0, RK_FLINE);
    ret(16'h2000, 3'h0, 3'h0, RK_TRACE);
    ret(16'h1000, 3'h7, 3'h2, RK_MOVE_STACKED_EA);
    ret(16'h1000, 3'h7, 3'h3, RK_MOVE_STACKED_EA);
    ret(16'h1000, 3'h6, 3'h0, RK_MOVE_STACKED_EA);
    ret(16'h1000, 3'h2, 3'h0, RK_MOVE_RECALC_EA);
    wr(REG_CTRL, 32'h0030_0010);
    rd(REG_CTRL, 32'h0030_0010, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    complete_run;
  end
endmodule : access_fault_frame_builder_test
